// [hw/ssx_serial_port.sv]
// design: eight-bit synchronous serial port with ahb-lite register slave
// ------------------------------------------------------------
// How it works
// [R1] transmit bits leave on the leading edge, receive bits sampled on trailing
// [R2] leading edge is clock pin falling, trailing is rising, both clock sources
// [R3] one bit-order bit serves transmit and receive alike
// [R4] software changes bit order only while transfer-active reads zero
// [R5] order zero sends msb first, order one sends lsb first
// [R6] mode field 00 selects transmit only
// [R7] mode field 01 selects receive only
// [R8] mode field 10 selects full duplex
// [R9] internal clock output idles high before and after transfers
// [R10] writing the transmit buffer clears the buffer-empty flag
// [R11] transfer-active flag rises on a falling clock edge after start
// [R12] one transmit bit per falling edge in selected order
// [R13] shift-active high from first to eighth falling edge of a byte
// [R14] buffer-empty set on rising edge after load, interrupt next falling edge in transmit-only mode
// [R15] internal clock waits for buffered byte before starting
// [R16] internal clock loads and starts clocking within one serial period
// [R17] external clock loads the byte on the first falling edge after start
// [R18] internal clock stops high when empty, write resumes within one period
// [R19] byte written before current byte ends follows back to back
// [R20] external underrun sets transmit error and interrupt together at shift start
// [R21] clearing start finishes current byte, clears active, holds output high
// [R22] with external clock, clear start before next byte's shift begins
// [R23] forced stop halts at once, resets start, status and both buffers
// [R24] eight bits per byte through an eight-bit shift register
// ------------------------------------------------------------
//
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module ssx_serial_port
(
	input wire logic CLK_SYS_IN,
	input wire logic RESET_N_IN,
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic [31:0] HRDATA_OUT,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT,
	input wire logic SCK_IN,
	output logic SCK_OUT,
	output logic SCK_OE_OUT,
	input wire logic SI_IN,
	output logic SO_OUT,
	output logic SERIAL_IRQ_OUT
);

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_s1_r;
	logic rst_n_r;

	always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ssx_pkg::ssx_state_t s_r;
	ssx_pkg::ssx_state_t s_nxt;

	localparam ssx_pkg::ssx_state_t SSX_STATE_RST = '{
		ctrl: ssx_pkg::SSX_CTRL_RST,
		stat: ssx_pkg::SSX_STAT_RST,
		phase: ssx_pkg::SSX_PH_IDLE,
		tx_buf: 8'h00,
		rx_buf: 8'h00,
		tx_sh: ssx_pkg::SSX_IDLE_BYTE,
		rx_sh: 8'h00,
		bit_cnt: 3'h0,
		empty_pend: 1'b0,
		tx_irq_pend: 1'b0,
		div_cnt: 12'h000,
		sck_lvl: 1'b1,
		so: 1'b1,
		irq: 1'b0,
		sck_s1: 1'b1,
		sck_s2: 1'b1,
		sck_s3: 1'b1,
		si_s1: 1'b1,
		si_s2: 1'b1,
		wr_pend: 1'b0,
		wr_addr: 8'h00,
		rdata: 32'h0000_0000
	};

	always_ff @(posedge CLK_SYS_IN or negedge rst_n_r)
	begin
		if (!rst_n_r)
			s_r <= SSX_STATE_RST;
		else
			s_r <= s_nxt;
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic ext_clk;
		logic ext_fall;
		logic ext_rise;
		logic int_fall;
		logic int_rise;
		logic fall;
		logic rise;
		logic tx_mode;
		logic rx_mode;
		logic data_ok;
		logic go_ok;
		logic force_stop;
		logic addr_ph;
		logic [11:0] half;
		logic [7:0] rx_next;
		logic [7:0] wdat;
		ssx_pkg::ssx_stat_t clr;

		s_nxt = s_r;
		ext_clk = (s_r.ctrl.sck_sel == ssx_pkg::SSX_SCK_EXT);
		int_fall = 1'b0;
		int_rise = 1'b0;
		force_stop = 1'b0;
		rx_next = s_r.rx_sh;
		wdat = HWDATA_IN[7:0];
		clr = s_r.stat;
		s_nxt.irq = 1'b0;

		// pin synchronisers; edges come from the second and third stage
		s_nxt.sck_s1 = SCK_IN;
		s_nxt.sck_s2 = s_r.sck_s1;
		s_nxt.sck_s3 = s_r.sck_s2;
		s_nxt.si_s1 = SI_IN;
		s_nxt.si_s2 = s_r.si_s1;
		ext_fall = s_r.sck_s3 & ~s_r.sck_s2; // [R2]
		ext_rise = ~s_r.sck_s3 & s_r.sck_s2; // [R2]

		tx_mode = (s_r.ctrl.mode == ssx_pkg::SSX_MODE_TX) ||
			(s_r.ctrl.mode == ssx_pkg::SSX_MODE_TRX); // [R6] [R8]
		rx_mode = (s_r.ctrl.mode == ssx_pkg::SSX_MODE_RX) ||
			(s_r.ctrl.mode == ssx_pkg::SSX_MODE_TRX); // [R7] [R8]

		// ------------------------------------------------------------
		// bus address phase: read data and read side effects
		// ------------------------------------------------------------
		addr_ph = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
		s_nxt.wr_pend = addr_ph && HWRITE_IN;
		if (addr_ph)
			s_nxt.wr_addr = HADDR_IN[7:0];
		if (addr_ph && !HWRITE_IN)
		begin
			unique case (HADDR_IN[7:0])
				ssx_pkg::SSX_OFS_CTRL:
					s_nxt.rdata = {24'h00_0000, s_r.ctrl};
				ssx_pkg::SSX_OFS_STAT:
					s_nxt.rdata = {26'h00_0000, s_r.stat};
				ssx_pkg::SSX_OFS_RXB:
				begin
					s_nxt.rdata = {24'h00_0000, s_r.rx_buf};
					s_nxt.stat.rx_full = 1'b0;
				end
				default:
					s_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// ------------------------------------------------------------
		// bus data phase: writes
		// ------------------------------------------------------------
		if (s_r.wr_pend)
		begin
			unique case (s_r.wr_addr)
				ssx_pkg::SSX_OFS_CTRL:
				begin
					s_nxt.ctrl = wdat;
					s_nxt.ctrl.stop = 1'b0;
					force_stop = wdat[ssx_pkg::SSX_CTRL_STOP_POS];
				end
				ssx_pkg::SSX_OFS_STAT:
				begin
					if (!wdat[ssx_pkg::SSX_STAT_TX_UNDERRUN_FLAG_POS])
						s_nxt.stat.tx_err = 1'b0;
					if (!wdat[ssx_pkg::SSX_STAT_RXERR_POS] && s_r.stat.rx_err)
					begin
						s_nxt.stat.rx_err = 1'b0;
						s_nxt.stat.rx_full = 1'b0;
					end
				end
				ssx_pkg::SSX_OFS_TXB:
				begin
					// a write while the buffer still holds a byte is dropped
					if (s_r.stat.tx_empty)
					begin
						s_nxt.tx_buf = wdat;
						s_nxt.stat.tx_empty = 1'b0; // [R10]
					end
				end
				default:
				begin
				end
			endcase
		end

		// ------------------------------------------------------------
		// internal clock generator with automatic wait
		// ------------------------------------------------------------
		data_ok = 1'b1;
		if (tx_mode && s_r.stat.tx_empty)
			data_ok = 1'b0; // [R15] [R18]
		if (rx_mode && (s_r.stat.rx_full || s_r.stat.rx_err))
			data_ok = 1'b0;
		if (!tx_mode && !rx_mode)
			data_ok = 1'b0;
		go_ok = (s_r.phase == ssx_pkg::SSX_PH_SHIFT) ||
			(s_r.ctrl.start && data_ok);
		half = ssx_pkg::SSX_HALF_BASE << s_r.ctrl.sck_sel;
		if (ext_clk)
		begin
			s_nxt.sck_lvl = 1'b1;
			s_nxt.div_cnt = 12'h000;
		end
		else if (s_r.div_cnt < half - 12'h001)
			s_nxt.div_cnt = s_r.div_cnt + 12'h001;
		else
		begin
			// a waiting clock leaves its high level at most one period
			// after the wait is released
			s_nxt.div_cnt = 12'h000;
			if (!s_r.sck_lvl)
			begin
				int_rise = 1'b1;
				s_nxt.sck_lvl = 1'b1;
			end
			else if (go_ok)
			begin
				int_fall = 1'b1; // [R16] [R18]
				s_nxt.sck_lvl = 1'b0;
			end
		end
		fall = ext_clk ? ext_fall : int_fall; // [R2]
		rise = ext_clk ? ext_rise : int_rise; // [R2]

		// ------------------------------------------------------------
		// falling edge: start of byte or next transmit bit
		// ------------------------------------------------------------
		if (fall)
		begin
			if (s_r.tx_irq_pend)
			begin
				s_nxt.irq = 1'b1; // [R14]
				s_nxt.tx_irq_pend = 1'b0;
			end
			if (s_r.phase != ssx_pkg::SSX_PH_SHIFT)
			begin
				if (s_r.ctrl.start && (tx_mode || rx_mode))
				begin
					s_nxt.phase = ssx_pkg::SSX_PH_SHIFT;
					s_nxt.stat.active = 1'b1; // [R11]
					s_nxt.stat.shifting = 1'b1; // [R13]
					s_nxt.bit_cnt = 3'h0;
					s_nxt.so = 1'b1;
					s_nxt.tx_sh = ssx_pkg::SSX_IDLE_BYTE;
					if (tx_mode && !s_r.stat.tx_empty)
					begin
						// buffered byte enters the shifter at once
						s_nxt.tx_sh = s_r.tx_buf; // [R17] [R19]
						s_nxt.empty_pend = 1'b1;
						s_nxt.so = (s_r.ctrl.order == ssx_pkg::SSX_ORDER_MSB) ?
							s_r.tx_buf[7] : s_r.tx_buf[0]; // [R1] [R5] [R12]
					end
					else if (tx_mode)
					begin
						s_nxt.stat.tx_err = 1'b1; // [R20]
						s_nxt.irq = 1'b1; // [R20]
					end
				end
			end
			else
			begin
				s_nxt.bit_cnt = s_r.bit_cnt + 3'h1; // [R24]
				if (s_r.bit_cnt == ssx_pkg::SSX_PRE_LAST_BIT)
					s_nxt.stat.shifting = 1'b0; // [R13]
				if (s_r.ctrl.order == ssx_pkg::SSX_ORDER_MSB) // [R3] [R5]
				begin
					s_nxt.tx_sh = {s_r.tx_sh[6:0], 1'b1};
					s_nxt.so = s_r.tx_sh[6]; // [R12]
				end
				else
				begin
					s_nxt.tx_sh = {1'b1, s_r.tx_sh[7:1]};
					s_nxt.so = s_r.tx_sh[1]; // [R12]
				end
				if (!tx_mode || s_r.stat.tx_err)
					s_nxt.so = 1'b1;
			end
		end

		// ------------------------------------------------------------
		// rising edge: receive sample and end of byte
		// ------------------------------------------------------------
		if (rise && (s_r.phase == ssx_pkg::SSX_PH_SHIFT))
		begin
			if (s_r.empty_pend)
			begin
				s_nxt.empty_pend = 1'b0;
				s_nxt.stat.tx_empty = 1'b1; // [R14]
				s_nxt.tx_irq_pend = (s_r.ctrl.mode == ssx_pkg::SSX_MODE_TX);
			end
			if (s_r.ctrl.order == ssx_pkg::SSX_ORDER_MSB) // [R3] [R5]
				rx_next = {s_r.rx_sh[6:0], s_r.si_s2}; // [R1]
			else
				rx_next = {s_r.si_s2, s_r.rx_sh[7:1]}; // [R1]
			s_nxt.rx_sh = rx_next;
			if (s_r.bit_cnt == ssx_pkg::SSX_LAST_BIT) // [R24]
			begin
				if (rx_mode && !s_r.stat.rx_err)
				begin
					if (s_r.stat.rx_full && ext_clk)
					begin
						s_nxt.stat.rx_err = 1'b1;
						s_nxt.irq = 1'b1;
					end
					else
					begin
						s_nxt.rx_buf = rx_next;
						s_nxt.stat.rx_full = 1'b1;
						s_nxt.irq = 1'b1;
					end
				end
				if (s_r.ctrl.start)
					s_nxt.phase = ssx_pkg::SSX_PH_GAP; // [R19]
				else
				begin
					s_nxt.phase = ssx_pkg::SSX_PH_IDLE;
					s_nxt.stat.active = 1'b0; // [R21]
					s_nxt.so = 1'b1; // [R21]
				end
			end
		end

		// start cleared while waiting between bytes ends the transfer
		if ((s_r.phase == ssx_pkg::SSX_PH_GAP) && !s_r.ctrl.start && !fall)
		begin
			s_nxt.phase = ssx_pkg::SSX_PH_IDLE;
			s_nxt.stat.active = 1'b0; // [R21]
			s_nxt.so = 1'b1; // [R21]
		end

		// transmit output stays high while an underrun is flagged
		if (s_nxt.stat.tx_err)
			s_nxt.so = 1'b1;

		// ------------------------------------------------------------
		// forced stop overrides everything
		// ------------------------------------------------------------
		if (force_stop)
		begin
			s_nxt.ctrl.start = 1'b0; // [R23]
			s_nxt.stat = ssx_pkg::SSX_STAT_RST; // [R23]
			s_nxt.tx_buf = 8'h00; // [R23]
			s_nxt.rx_buf = 8'h00; // [R23]
			s_nxt.phase = ssx_pkg::SSX_PH_IDLE;
			s_nxt.tx_sh = ssx_pkg::SSX_IDLE_BYTE;
			s_nxt.bit_cnt = 3'h0;
			s_nxt.empty_pend = 1'b0;
			s_nxt.tx_irq_pend = 1'b0;
			s_nxt.div_cnt = 12'h000;
			s_nxt.sck_lvl = 1'b1; // [R9]
			s_nxt.so = 1'b1;
			s_nxt.irq = 1'b0;
		end
		clr = s_nxt.stat;
		s_nxt.stat = clr;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign HRDATA_OUT = s_r.rdata;
	assign HREADYOUT_OUT = 1'b1;
	assign HRESP_OUT = 1'b0;
	assign SCK_OUT = s_r.sck_lvl; // [R9]
	assign SCK_OE_OUT = (s_r.ctrl.sck_sel != ssx_pkg::SSX_SCK_EXT);
	assign SO_OUT = s_r.so;
	assign SERIAL_IRQ_OUT = s_r.irq;

endmodule

// [inc/ssx_pkg.sv]
// package: register map, field layout, modes and timing of the serial port
package ssx_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] SSX_OFS_CTRL = 8'h00;
	localparam logic [7:0] SSX_OFS_STAT = 8'h04;
	localparam logic [7:0] SSX_OFS_TXB = 8'h08;
	localparam logic [7:0] SSX_OFS_RXB = 8'h0C;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int SSX_CTRL_STOP_POS = 1;
	localparam int SSX_STAT_TX_UNDERRUN_FLAG_POS = 4;
	localparam int SSX_STAT_RXERR_POS = 5;

	// ------------------------------------------------------------
	// modes and clock selection
	// ------------------------------------------------------------
	localparam logic [1:0] SSX_MODE_TX = 2'h0;
	localparam logic [1:0] SSX_MODE_RX = 2'h1;
	localparam logic [1:0] SSX_MODE_TRX = 2'h2;
	localparam logic [2:0] SSX_SCK_EXT = 3'h7;
	localparam logic SSX_ORDER_MSB = 1'b0;

	// ------------------------------------------------------------
	// reset values and timing
	// ------------------------------------------------------------
	localparam logic [7:0] SSX_CTRL_RST = 8'h00;
	localparam logic [5:0] SSX_STAT_RST = 6'h04;
	localparam logic [7:0] SSX_IDLE_BYTE = 8'hFF;
	localparam logic [2:0] SSX_LAST_BIT = 3'h7;
	localparam logic [2:0] SSX_PRE_LAST_BIT = 3'h6;
	// internal half period in system clocks is this base shifted by the
	// clock select field
	localparam logic [11:0] SSX_HALF_BASE = 12'h0002;

	typedef enum logic [2:0] {
		SSX_PH_IDLE = 3'b001,
		SSX_PH_SHIFT = 3'b010,
		SSX_PH_GAP = 3'b100
	} ssx_phase_t;

	typedef struct packed {
		logic [2:0] sck_sel;
		logic [1:0] mode;
		logic order;
		logic stop;
		logic start;
	} ssx_ctrl_t;

	typedef struct packed {
		logic rx_err;
		logic tx_err;
		logic rx_full;
		logic tx_empty;
		logic shifting;
		logic active;
	} ssx_stat_t;

	typedef struct packed {
		ssx_ctrl_t ctrl;
		ssx_stat_t stat;
		ssx_phase_t phase;
		logic [7:0] tx_buf;
		logic [7:0] rx_buf;
		logic [7:0] tx_sh;
		logic [7:0] rx_sh;
		logic [2:0] bit_cnt;
		logic empty_pend;
		logic tx_irq_pend;
		logic [11:0] div_cnt;
		logic sck_lvl;
		logic so;
		logic irq;
		logic sck_s1;
		logic sck_s2;
		logic sck_s3;
		logic si_s1;
		logic si_s2;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} ssx_state_t;

endpackage

// [verif/ssx_ext_master.sv]
// partner: external master that clocks the port from its pin
`timescale 1ns/1ps
module ssx_ext_master
(
	output logic sck_out,
	output logic si_out,
	input wire logic so_in
);
	logic busy;
	initial
	begin
		sck_out = 1'b1;
		si_out = 1'b0;
		busy = 1'b0;
	end
	// idle data line toggles so a stale bit never reads as data
	always #50
		if (!busy)
			si_out = ~si_out;
	// eight clocks of 400 ns, clock stands high between frames
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		busy = 1'b1;
		for (int i = 7; i >= 0; i--)
		begin
			sck_out = 1'b0;
			si_out = tx[i];
			#200;
			sck_out = 1'b1;
			#195;
			rx[i] = so_in;
			#5;
		end
		busy = 1'b0;
	endtask
endmodule

// [verif/ssx_properties.sv]
// checker: port-level assertions of the serial port
`timescale 1ns/1ps
module ssx_properties
(
	input wire logic CLK_SYS_IN,
	input wire logic RESET_N_IN,
	input wire logic HREADYOUT_OUT,
	input wire logic HRESP_OUT,
	input wire logic SCK_IN,
	input wire logic SCK_OUT,
	input wire logic SCK_OE_OUT,
	input wire logic SO_OUT,
	input wire logic SERIAL_IRQ_OUT
);
	// ------------------------------------------------------------
	// clocking and sequences
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (!RESET_N_IN);
	sequence s_low_hold;
		!SCK_OUT ##1 !SCK_OUT;
	endsequence
	sequence s_low_end;
		##[1:300] SCK_OUT;
	endsequence
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	chk_idle_high: assert property ($rose(RESET_N_IN) |-> SCK_OUT && SO_OUT)
		else $error("serial lines not idle high after reset");
	chk_low_min: assert property ($fell(SCK_OUT) |-> s_low_hold)
		else $error("internal clock low phase too short");
	chk_low_max: assert property ($fell(SCK_OUT) |-> s_low_end)
		else $error("internal clock stuck low");
	chk_so_lead_int: assert property (SCK_OE_OUT && $fell(SO_OUT) |-> !SCK_OUT)
		else $error("data changed outside internal low phase");
	chk_so_lead_ext: assert property (!SCK_OE_OUT && $fell(SO_OUT)
		|-> $past(SCK_IN, 2) == 1'b0)
		else $error("data changed outside external low phase");
	chk_irq_pulse: assert property ($rose(SERIAL_IRQ_OUT) |=> !SERIAL_IRQ_OUT)
		else $error("interrupt longer than one cycle");
	chk_irq_on_fall: assert property (SERIAL_IRQ_OUT && SCK_OE_OUT
		|-> !SCK_OUT)
		else $error("transmit interrupt not at falling edge");
	chk_bus_okay: assert property (HRESP_OUT == 1'b0 && HREADYOUT_OUT == 1'b1)
		else $error("bus response not okay and ready");
endmodule

// [verif/tb_top.sv]
// testbench: register-level tests of the serial port
`timescale 1ns/1ps
module tb_top;
	logic clk, rst_n, hsel, hwrite, hready, hresp, sck_o, sck_oe, so, irq;
	logic sck_q, ext_sck, si, sck_in;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [7:0] rxb, e;
	logic bits[$];
	int miscompares, samples_checked, irqs, gap;
	int gaps[$];
	assign sck_in = sck_oe ? sck_o : ext_sck;
	ssx_serial_port uut (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n),
		.HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
		.HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
		.HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
		.HRESP_OUT(hresp), .SCK_IN(sck_in), .SCK_OUT(sck_o),
		.SCK_OE_OUT(sck_oe), .SI_IN(si), .SO_OUT(so), .SERIAL_IRQ_OUT(irq));
	ssx_ext_master ext (.sck_out(ext_sck), .si_out(si), .so_in(so));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ------------------------------------------------------------
	// monitor: bits at internal rises, rise spacing, interrupts
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		sck_q <= sck_o;
		gap <= gap + 1;
		if (irq === 1'b1)
			irqs <= irqs + 1;
		if (sck_oe && sck_o && !sck_q)
		begin
			bits.push_back(so);
			gaps.push_back(gap);
			gap <= 1;
		end
	end
	task automatic stop_test;
		if (miscompares == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic timeout_hit;
		chk(32'h0000_0001, 32'h0000_0000);
		stop_test;
	endtask
	task automatic edge_rdy;
		int t;
		t = 0;
		@(posedge clk);
		while (hready !== 1'b1)
		begin
			t++;
			if (t > 50)
				timeout_hit;
			@(posedge clk);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {{24{1'b0}}, a};
		hwrite <= w;
		hsize <= 3'h2;
		edge_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		edge_rdy;
		rd = hrdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] x);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, x);
	endtask
	task automatic wait_stat(input logic [31:0] m);
		int t;
		t = 0;
		bus(1'b0, ssx_pkg::SSX_OFS_STAT, 32'h0000_0000);
		while ((rd & m) !== m)
		begin
			t++;
			if (t > 300)
				timeout_hit;
			bus(1'b0, ssx_pkg::SSX_OFS_STAT, 32'h0000_0000);
		end
	endtask
	task automatic wait_bits(input int k);
		int t;
		t = 0;
		while (bits.size() < k)
		begin
			@(posedge clk);
			t++;
			if (t > 300)
				timeout_hit;
		end
	endtask
	task automatic xf(input logic [7:0] tx);
		// link pin changes stay off the sampling edge
		@(negedge clk);
		ext.xfer(tx, rxb);
		@(posedge clk);
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		rst_n = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0000_0000;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		miscompares = 0;
		samples_checked = 0;
		irqs = 0;
		gap = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rchk(ssx_pkg::SSX_OFS_CTRL, 32'h0000_0000);
		rchk(ssx_pkg::SSX_OFS_STAT, 32'h0000_0004);
		bus(1'b1, 8'h10, 32'hFFFF_FFFF);
		rchk(8'h10, 32'h0000_0000);
		rchk(ssx_pkg::SSX_OFS_TXB, 32'h0000_0000);
		for (int o = 0; o < 2; o++)
		begin
			bits.delete();
			gaps.delete();
			irqs = 0;
			bus(1'b1, ssx_pkg::SSX_OFS_CTRL, o ? 32'h0000_0005 : 32'h0000_0001);
			repeat (8) @(posedge clk);
			chk(bits.size(), 0);
			rchk(ssx_pkg::SSX_OFS_STAT, 32'h0000_0004);
			bus(1'b1, ssx_pkg::SSX_OFS_TXB, 32'h0000_00C1);
			wait_stat(32'h0000_0004);
			bus(1'b1, ssx_pkg::SSX_OFS_TXB, 32'h0000_003A);
			wait_bits(16);
			bus(1'b1, ssx_pkg::SSX_OFS_CTRL, o ? 32'h0000_0004 : 32'h0000_0000);
			// active drops one clock after start is seen cleared
			@(posedge clk);
			bus(1'b0, ssx_pkg::SSX_OFS_STAT, 32'h0000_0000);
			chk(rd & 32'h0000_0001, 32'h0000_0000);
			chk({so, sck_o}, 2'b11);
			for (int i = 0; i < 16; i++)
			begin
				e = (i < 8) ? 8'hC1 : 8'h3A;
				chk(bits[i], o ? e[i % 8] : e[7 - i % 8]);
				if (i > 0)
					chk(gaps[i], 4);
			end
			chk(irqs, 2);
		end
		bus(1'b1, ssx_pkg::SSX_OFS_CTRL, 32'h0000_00E0);
		bus(1'b1, ssx_pkg::SSX_OFS_TXB, 32'h0000_005B);
		rchk(ssx_pkg::SSX_OFS_STAT, 32'h0000_0000);
		bus(1'b1, ssx_pkg::SSX_OFS_CTRL, 32'h0000_00E1);
		xf(8'h00);
		chk(rxb, 8'h5B);
		xf(8'h00);
		chk(rxb, 8'hFF);
		wait_stat(32'h0000_0010);
		bus(1'b1, ssx_pkg::SSX_OFS_CTRL, 32'h0000_00E2);
		rchk(ssx_pkg::SSX_OFS_CTRL, 32'h0000_00E0);
		rchk(ssx_pkg::SSX_OFS_STAT, 32'h0000_0004);
		bus(1'b1, ssx_pkg::SSX_OFS_CTRL, 32'h0000_00EC);
		bus(1'b1, ssx_pkg::SSX_OFS_CTRL, 32'h0000_00ED);
		xf(8'h6B);
		wait_stat(32'h0000_0008);
		rchk(ssx_pkg::SSX_OFS_RXB, 32'h0000_00D6);
		bus(1'b1, ssx_pkg::SSX_OFS_CTRL, 32'h0000_00EE);
		bus(1'b1, ssx_pkg::SSX_OFS_CTRL, 32'h0000_00F0);
		bus(1'b1, ssx_pkg::SSX_OFS_TXB, 32'h0000_0047);
		bus(1'b1, ssx_pkg::SSX_OFS_CTRL, 32'h0000_00F1);
		xf(8'h9C);
		chk(rxb, 8'h47);
		wait_stat(32'h0000_0008);
		rchk(ssx_pkg::SSX_OFS_RXB, 32'h0000_009C);
		bus(1'b1, ssx_pkg::SSX_OFS_CTRL, 32'h0000_00F2);
		rchk(ssx_pkg::SSX_OFS_RXB, 32'h0000_0000);
		stop_test;
	end
endmodule
bind ssx_serial_port ssx_properties chk_i (.CLK_SYS_IN(CLK_SYS_IN),
	.RESET_N_IN(RESET_N_IN), .HREADYOUT_OUT(HREADYOUT_OUT),
	.HRESP_OUT(HRESP_OUT), .SCK_IN(SCK_IN), .SCK_OUT(SCK_OUT),
	.SCK_OE_OUT(SCK_OE_OUT), .SO_OUT(SO_OUT),
	.SERIAL_IRQ_OUT(SERIAL_IRQ_OUT));
